// [rtl/pmx_port_pin_mux.sv]
// Port pin function multiplexer with APB register access for port T
//
// The implementer's own choice: register access over APB.
module pmx_port_pin_mux
  import pmx_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_ch_en,
  input wire logic [5:0] tim_out,
  input wire logic [5:0] tim_oc_en,
  output logic [5:0] tim_in,
  input wire logic sci_tx_en,
  input wire logic sci_tx_val,
  input wire logic sci_rx_en,
  output logic sci_rx_data,
  input wire logic spi_en,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] spi_oe,
  output logic [3:0] spi_in,
  input wire logic can_en,
  input wire logic can_tx_line,
  output logic can_rx_line,
  input wire logic [3:0] gpio_s_out,
  input wire logic [3:0] gpio_s_dir,
  output logic [3:0] gpio_s_in,
  input wire logic [5:0] gpio_m_out,
  input wire logic [5:0] gpio_m_dir,
  output logic [5:0] gpio_m_in,
  input wire logic [7:0] gpio_p_out,
  input wire logic [7:0] gpio_p_dir,
  output logic [7:0] gpio_p_in,
  input wire logic [1:0] gpio_j_out,
  input wire logic [1:0] gpio_j_dir,
  output logic [1:0] gpio_j_in,
  input wire logic [7:0] port_t_pin_in,
  output pmx_pad8_s port_t_pin,
  output pmx_padcfg_s port_t_cfg,
  input wire logic [3:0] port_s_pin_in,
  output logic [3:0] port_s_pin_out,
  output logic [3:0] port_s_pin_oe,
  input wire logic [5:0] port_m_pin_in,
  output logic [5:0] port_m_pin_out,
  output logic [5:0] port_m_pin_oe,
  input wire logic [7:0] port_p_pin_in,
  output pmx_pad8_s port_p_pin,
  input wire logic [1:0] port_j_pin_in,
  output logic [1:0] port_j_pin_out,
  output logic [1:0] port_j_pin_oe
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Accept a new level only where second and third stage agree
  function automatic logic [PMX_SY_W-1:0] sync_accept(
    input logic [PMX_SY_W-1:0] prev,
    input logic [PMX_SY_W-1:0] s2,
    input logic [PMX_SY_W-1:0] s3
  );
    sync_accept = (s2 & s3) | (prev & (s2 ^ s3));
  endfunction : sync_accept

  // Write a byte lane honouring its strobe
  function automatic logic [7:0] lane_write(
    input logic [7:0] cur,
    input logic [31:0] wdata,
    input logic strobe
  );
    lane_write = strobe ? wdata[7:0] : cur;
  endfunction : lane_write

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] t_data_r, t_dir_r, t_drive_r, t_pull_en_r, t_pull_pol_r, t_lvl;
  logic [PMX_ROUTE_W-1:0] route_r;
  logic [PMX_SY_W-1:0] sy1_r, sy2_r, sy3_r, pin_lvl_r, raw_pins;
  logic [9:0] idx;
  logic idx_ok, wr_en, setup_ph;
  logic [31:0] prdata_r, rd_nxt;
  pmx_pad8_s t_nxt, p_nxt, t_pad_r, p_pad_r;
  logic [3:0] s_out_nxt, s_oe_nxt, s_out_r, s_oe_r;
  logic [5:0] m_out_nxt, m_oe_nxt, m_out_r, m_oe_r;
  logic [1:0] j_out_r, j_oe_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = paddr[11:2];
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign idx_ok = (idx == PMX_IDX_T_DATA) || (idx == PMX_IDX_T_INPUT)
    || (idx == PMX_IDX_T_DIR) || (idx == PMX_IDX_T_DRIVE)
    || (idx == PMX_IDX_T_PULL_EN) || (idx == PMX_IDX_T_PULL_POL)
    || (idx == PMX_IDX_ROUTE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !idx_ok;
  assign prdata = prdata_r;

  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    unique case (idx)
      PMX_IDX_T_DATA: rd_nxt[7:0] = t_data_r;
      PMX_IDX_T_INPUT: rd_nxt[7:0] = t_lvl;
      PMX_IDX_T_DIR: rd_nxt[7:0] = t_dir_r;
      PMX_IDX_T_DRIVE: rd_nxt[7:0] = t_drive_r;
      PMX_IDX_T_PULL_EN: rd_nxt[7:0] = t_pull_en_r;
      PMX_IDX_T_PULL_POL: rd_nxt[7:0] = t_pull_pol_r;
      PMX_IDX_ROUTE: rd_nxt[PMX_ROUTE_W-1:0] = route_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Read data captured in setup, held through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (setup_ph)
      prdata_r <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // Port T registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_data_r <= PMX_RST_BYTE;
      t_dir_r <= PMX_RST_BYTE;
      t_drive_r <= PMX_RST_BYTE;
      t_pull_en_r <= PMX_RST_BYTE;
      t_pull_pol_r <= PMX_RST_BYTE;
    end
    else if (wr_en)
    begin
      unique case (idx)
        PMX_IDX_T_DATA: t_data_r <= lane_write(t_data_r, pwdata, pstrb[0]);
        PMX_IDX_T_DIR: t_dir_r <= lane_write(t_dir_r, pwdata, pstrb[0]);
        PMX_IDX_T_DRIVE: t_drive_r <= lane_write(t_drive_r, pwdata, pstrb[0]);
        PMX_IDX_T_PULL_EN: t_pull_en_r <= lane_write(t_pull_en_r, pwdata, pstrb[0]);
        PMX_IDX_T_PULL_POL: t_pull_pol_r <= lane_write(t_pull_pol_r, pwdata, pstrb[0]);
        default: t_data_r <= t_data_r;
      endcase
    end
  end

  // Route select, cleared at reset so no PWM reaches port T
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      route_r <= PMX_RST_ROUTE;
    else if (wr_en && idx == PMX_IDX_ROUTE && pstrb[0])
      route_r <= pwdata[PMX_ROUTE_W-1:0];
  end

  assign port_t_cfg.drive_reduce = t_drive_r;
  assign port_t_cfg.pull_en = t_pull_en_r;
  assign port_t_cfg.pull_up = t_pull_pol_r;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  assign raw_pins = {port_j_pin_in, port_p_pin_in, port_m_pin_in,
                     port_s_pin_in, port_t_pin_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sy1_r <= '0;
      sy2_r <= '0;
      sy3_r <= '0;
      pin_lvl_r <= '0;
    end
    else
    begin
      sy1_r <= raw_pins;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_lvl_r <= sync_accept(pin_lvl_r, sy2_r, sy3_r);
    end
  end

  assign t_lvl = pin_lvl_r[PMX_SY_T +: 8];
  assign tim_in = t_lvl[7:PMX_TIM_LO];
  assign sci_rx_data = sci_rx_en ? pin_lvl_r[PMX_SY_S] : 1'b1;
  assign gpio_s_in = pin_lvl_r[PMX_SY_S +: 4];
  assign spi_in = spi_en ? pin_lvl_r[PMX_SY_M+2 +: 4] : 4'h0;
  assign can_rx_line = can_en ? pin_lvl_r[PMX_SY_M] : 1'b1;
  assign gpio_m_in = pin_lvl_r[PMX_SY_M +: 6];
  assign gpio_p_in = pin_lvl_r[PMX_SY_P +: 8];
  assign gpio_j_in = pin_lvl_r[PMX_SY_J +: 2];

  // ----------------------------------------------------------------
  // Output function select
  // ----------------------------------------------------------------
  always_comb
  begin
    t_nxt.out = t_data_r;
    t_nxt.oe = t_dir_r;
    p_nxt.out = gpio_p_out;
    p_nxt.oe = gpio_p_dir;
    for (int i = 7; i >= PMX_TIM_LO; i--)
    begin
      if (tim_oc_en[i-PMX_TIM_LO])
      begin
        t_nxt.out[i] = tim_out[i-PMX_TIM_LO];
        t_nxt.oe[i] = 1'b1;
      end
    end
    for (int i = 0; i < PMX_PWM_N; i++)
    begin
      if (route_r[i] && pwm_ch_en[i])
      begin
        t_nxt.out[i] = pwm_out[i];
        t_nxt.oe[i] = 1'b1;
      end
      if (pwm_ch_en[i])
      begin
        p_nxt.out[i] = pwm_out[i];
        p_nxt.oe[i] = 1'b1;
      end
    end
  end

  always_comb
  begin
    s_out_nxt = gpio_s_out;
    s_oe_nxt = gpio_s_dir;
    if (sci_tx_en)
    begin
      s_out_nxt[1] = sci_tx_val;
      s_oe_nxt[1] = 1'b1;
    end
    if (sci_rx_en)
    begin
      s_out_nxt[0] = 1'b0;
      s_oe_nxt[0] = 1'b0;
    end
  end

  always_comb
  begin
    m_out_nxt = gpio_m_out;
    m_oe_nxt = gpio_m_dir;
    if (spi_en)
    begin
      m_out_nxt[5:2] = spi_out;
      m_oe_nxt[5:2] = spi_oe;
    end
    if (can_en)
    begin
      m_out_nxt[1:0] = {can_tx_line, 1'b0};
      m_oe_nxt[1:0] = 2'b10;
    end
  end

  // ----------------------------------------------------------------
  // Pad output registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_pad_r <= '0;
      p_pad_r <= '0;
      s_out_r <= '0;
      s_oe_r <= '0;
      m_out_r <= '0;
      m_oe_r <= '0;
      j_out_r <= '0;
      j_oe_r <= '0;
    end
    else
    begin
      t_pad_r <= t_nxt;
      p_pad_r <= p_nxt;
      s_out_r <= s_out_nxt;
      s_oe_r <= s_oe_nxt;
      m_out_r <= m_out_nxt;
      m_oe_r <= m_oe_nxt;
      j_out_r <= gpio_j_out;
      j_oe_r <= gpio_j_dir;
    end
  end

  assign port_t_pin = t_pad_r;
  assign port_p_pin = p_pad_r;
  assign port_s_pin_out = s_out_r;
  assign port_s_pin_oe = s_oe_r;
  assign port_m_pin_out = m_out_r;
  assign port_m_pin_oe = m_oe_r;
  assign port_j_pin_out = j_out_r;
  assign port_j_pin_oe = j_oe_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pwm_over_tim_a: assert property (
    route_r[2] && pwm_ch_en[2] && tim_oc_en[0]
      |=> port_t_pin.out[2] == $past(pwm_out[2]) && port_t_pin.oe[2])
    else $error("Timer won over routed PWM on port T pin 2");
  tim_over_gpio_a: assert property (
    tim_oc_en[5] && !t_dir_r[7]
      |=> port_t_pin.oe[7] && port_t_pin.out[7] == $past(tim_out[5]))
    else $error("Timer channel not driving port T pin 7");
  reset_gpio_a: assert property (
    !$past(presetn) |-> route_r == 5'h00 && port_t_pin.oe == 8'h00)
    else $error("Port T not plain input after reset");
  sci_tx_a: assert property (
    sci_tx_en |=> port_s_pin_oe[1] && port_s_pin_out[1] == $past(sci_tx_val))
    else $error("Serial transmit not on port S pin 1");
  sci_rx_a: assert property (
    sci_rx_en && $stable(sy3_r[PMX_SY_S]) && sy2_r[PMX_SY_S] == sy3_r[PMX_SY_S]
      |=> sci_rx_data == (sci_rx_en ? $past(sy3_r[PMX_SY_S]) : 1'b1)
      && !port_s_pin_oe[0])
    else $error("Serial receive not fed from port S pin 0");
  spi_can_a: assert property (
    spi_en && can_en |=> port_m_pin_out[5:2] == $past(spi_out)
      && port_m_pin_oe[5:2] == $past(spi_oe) && port_m_pin_out[1] == $past(can_tx_line))
    else $error("Port M not carrying serial and CAN lines");

  port_p_pwm_a: assert property (
    pwm_ch_en[3] |=> port_p_pin.oe[3] && port_p_pin.out[3] == $past(pwm_out[3]))
    else $error("Port P pin 3 not carrying PWM");
  dual_map_a: assert property (
    route_r[1] && pwm_ch_en[1]
      |=> port_t_pin.out[1] == port_p_pin.out[1] && port_t_pin.oe[1] && port_p_pin.oe[1])
    else $error("Routed PWM channel missing on one port");

  input_ro_a: assert property (
    wr_en && idx == PMX_IDX_T_INPUT |=> $stable(t_data_r) && $stable(t_dir_r))
    else $error("Write to input register changed state");

  gpio_data_a: assert property (
    t_dir_r[6] && !tim_oc_en[4] |=> port_t_pin.out[6] == $past(t_data_r[6]))
    else $error("Port T data not driven on output pin");

endmodule : pmx_port_pin_mux

// [rtl/pmx_pkg.sv]
// Package: register map, field layout and pad carriers of the port pin mux
package pmx_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] PMX_IDX_T_DATA = 10'h000;
  localparam logic [9:0] PMX_IDX_T_INPUT = 10'h001;
  localparam logic [9:0] PMX_IDX_T_DIR = 10'h002;
  localparam logic [9:0] PMX_IDX_T_DRIVE = 10'h003;
  localparam logic [9:0] PMX_IDX_T_PULL_EN = 10'h004;
  localparam logic [9:0] PMX_IDX_T_PULL_POL = 10'h005;
  localparam logic [9:0] PMX_IDX_ROUTE = 10'h007;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PMX_PORT_W = 8;
  localparam int PMX_ROUTE_W = 5;
  localparam int PMX_PWM_N = 4;
  localparam int PMX_TIM_LO = 2;
  localparam logic [7:0] PMX_RST_BYTE = 8'h00;
  localparam logic [4:0] PMX_RST_ROUTE = 5'h00;

  // ----------------------------------------------------------------
  // Sampled pin vector layout
  // ----------------------------------------------------------------
  localparam int PMX_SY_T = 0;
  localparam int PMX_SY_S = 8;
  localparam int PMX_SY_M = 12;
  localparam int PMX_SY_P = 18;
  localparam int PMX_SY_J = 26;
  localparam int PMX_SY_W = 28;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pmx_pad8_s;

  typedef struct packed {
    logic [7:0] drive_reduce;
    logic [7:0] pull_en;
    logic [7:0] pull_up;
  } pmx_padcfg_s;

endpackage : pmx_pkg

// [testbench/pmx_pin_model.sv]
// Board-side pad model: a pin follows the chip while driven, else the board level
module pmx_pin_model
#(
  parameter int W = 8
)
(
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pin = (out & oe) | (ext & ~oe);
endmodule : pmx_pin_model

// [testbench/pmx_port_pin_mux_tb.sv]
// Self-checking bench for the port pin function mux
module pmx_port_pin_mux_tb;
  import pmx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, pwo, pwe, spo, spe, spi, gso, gsd, gsi, si, so, se, xs;
  logic [5:0] tmo, tme, tmi, gmo, gmd, gmi, mi, mo, me, xm;
  logic txe, txv, rxe, rxd, spn, cnn, cnt, cnr;
  logic [7:0] gpo, gpd, gpi, ti, pi, xt, xp, dat, dir, rt, tl, ml;
  logic [1:0] gjo, gjd, gji, ji, jo, je, xj;
  logic [127:0] r;
  logic [7:0] w [7];
  int ix [7] = '{0, 1, 2, 3, 4, 5, 7};
  pmx_pad8_s tp, pad_p;
  pmx_padcfg_s tc;
  int failures, checks_done, seed;

  pmx_port_pin_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwo), .pwm_ch_en(pwe), .tim_out(tmo),
    .tim_oc_en(tme), .tim_in(tmi), .sci_tx_en(txe), .sci_tx_val(txv), .sci_rx_en(rxe),
    .sci_rx_data(rxd), .spi_en(spn), .spi_out(spo), .spi_oe(spe), .spi_in(spi),
    .can_en(cnn), .can_tx_line(cnt), .can_rx_line(cnr), .gpio_s_out(gso), .gpio_s_dir(gsd),
    .gpio_s_in(gsi), .gpio_m_out(gmo), .gpio_m_dir(gmd), .gpio_m_in(gmi), .gpio_p_out(gpo),
    .gpio_p_dir(gpd), .gpio_p_in(gpi), .gpio_j_out(gjo), .gpio_j_dir(gjd), .gpio_j_in(gji),
    .port_t_pin_in(ti), .port_t_pin(tp), .port_t_cfg(tc), .port_s_pin_in(si),
    .port_s_pin_out(so), .port_s_pin_oe(se), .port_m_pin_in(mi), .port_m_pin_out(mo),
    .port_m_pin_oe(me), .port_p_pin_in(pi), .port_p_pin(pad_p), .port_j_pin_in(ji),
    .port_j_pin_out(jo), .port_j_pin_oe(je));
  pmx_pin_model #(.W(8)) m_t (.out(tp.out), .oe(tp.oe), .ext(xt), .pin(ti));
  pmx_pin_model #(.W(8)) m_p (.out(pad_p.out), .oe(pad_p.oe), .ext(xp), .pin(pi));
  pmx_pin_model #(.W(4)) m_s (.out(so), .oe(se), .ext(xs), .pin(si));
  pmx_pin_model #(.W(6)) m_m (.out(mo), .oe(me), .ext(xm), .pin(mi));
  pmx_pin_model #(.W(2)) m_j (.out(jo), .oe(je), .ext(xj), .pin(ji));

  always #10 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input int idx, input logic [7:0] wd, input logic [3:0] sb);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= {24'h00_0000, wd};
    pstrb <= sb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20)
      failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] msk(input logic [7:0] o, input logic [7:0] e);
    return {o & e, e};
  endfunction : msk

  function automatic logic [7:0] lvl(input logic [15:0] m, input logic [7:0] x);
    return m[15:8] | (x & ~m[7:0]);
  endfunction : lvl

  function automatic logic [15:0] exp_t();
    logic [7:0] pe, tv;
    pe = {4'h0, rt[3:0] & pwe};
    tv = {tme, 2'b00};
    return msk((pe & {4'h0, pwo}) | (~pe & tv & {tmo, 2'b00}) | (~pe & ~tv & dat), pe | tv | dir);
  endfunction : exp_t

  function automatic logic [15:0] exp_p();
    logic [7:0] pe;
    pe = {4'h0, pwe};
    return msk((pe & {4'h0, pwo}) | (~pe & gpo), pe | gpd);
  endfunction : exp_p

  function automatic logic [15:0] exp_s();
    logic [3:0] tx, rx;
    tx = {2'b00, txe, 1'b0};
    rx = {3'b000, rxe};
    return msk((tx & {4{txv}}) | (~tx & gso), (tx | gsd) & ~rx);
  endfunction : exp_s

  function automatic logic [15:0] exp_m();
    logic [5:0] sm, cm, c0;
    sm = {{4{spn}}, 2'b00};
    cm = {4'h0, cnn, 1'b0};
    c0 = {5'h00, cnn};
    return msk((sm & {spo, 2'b00}) | (cm & {6{cnt}}) | (~sm & ~cm & gmo),
               (sm & {spe, 2'b00}) | cm | (~sm & ~cm & ~c0 & gmd));
  endfunction : exp_m

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'h99ad_4058;
    failures = 0;
    checks_done = 0;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {pwo, pwe, tmo, tme, txe, txv, rxe, spn, spo, spe, cnn, cnt} = '0;
    {gso, gsd, gmo, gmd, gpo, gpd, gjo, gjd, xt, xp, xs, xm, xj} = '0;
    {dat, dir, rt} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ix[i], 8'h00, 4'hf);
      chk(rd, 32'h0000_0000);
    end
    chk(msk(tp.out, tp.oe), 16'h0000);
    chk(tc, 24'h00_0000);
    $display("test reset done");
    for (int i = 0; i < 7; i++)
    begin
      w[i] = $random(seed);
      apb(1'b1, ix[i], w[i], 4'hf);
      apb(1'b0, ix[i], 8'h00, 4'hf);
      chk({er, rd}, (i == 1) ? 0 : (i == 6) ? w[i] & 8'h1f : w[i]);
    end
    apb(1'b1, 0, ~w[0], 4'he);
    apb(1'b0, 0, 8'h00, 4'hf);
    chk(rd, w[0]);
    apb(1'b1, 6, 8'hff, 4'hf);
    chk(er, 1'b1);
    apb(1'b0, 6, 8'h00, 4'hf);
    chk({er, rd}, 33'h1_0000_0000);
    chk(tc, {w[3], w[4], w[5]});
    $display("test registers done");
    for (int k = 0; k < 24; k++)
    begin
      dat = $random(seed);
      dir = $random(seed);
      rt = (k == 0) ? 8'hff : $random(seed);
      r = (k == 0) ? '1 : {$random(seed), $random(seed), $random(seed), $random(seed)};
      apb(1'b1, 0, dat, 4'hf);
      apb(1'b1, 2, dir, 4'hf);
      apb(1'b1, 7, rt, 4'hf);
      @(posedge pclk);
      {pwo, pwe, tmo, tme, txe, txv, rxe, spn, spo, spe, cnn, cnt} <= r[101:68];
      {gso, gsd, gmo, gmd, gpo, gpd, gjo, gjd, xt, xp, xs, xm, xj} <= r[67:0];
      repeat (8) @(posedge pclk);
      tl = lvl(exp_t(), xt);
      ml = lvl(exp_m(), {2'b00, xm});
      chk(msk(tp.out, tp.oe), exp_t());
      chk(msk(pad_p.out, pad_p.oe), exp_p());
      chk(msk(so, se), exp_s());
      chk(msk(mo, me), exp_m());
      chk(msk(jo, je), msk(gjo, gjd));
      chk(tmi, tl[7:2]);
      chk(rxd, rxe ? xs[0] : 1'b1);
      chk(gsi, lvl(exp_s(), xs));
      chk(cnr, cnn ? xm[0] : 1'b1);
      chk(spi, spn ? ml[5:2] : 4'h0);
      chk(gmi, ml);
      chk(gpi, lvl(exp_p(), xp));
      chk(gji, lvl(msk(gjo, gjd), xj));
      apb(1'b0, 1, 8'h00, 4'hf);
      chk(rd, tl);
    end
    $display("test mux done");
    finish_test();
  end

  initial
  begin
    #200_000;
    failures++;
    finish_test();
  end
endmodule : pmx_port_pin_mux_tb
